// ### rtl/impr_pkg.sv
// Constants and types for the interrupt mask and priority block
package impr_pkg;
	localparam logic [7:0] ADDR_BASIC_PRIO = 8'hb8;
	localparam logic [7:0] ADDR_EXT_EN_ONE = 8'he6;
	localparam logic [7:0] ADDR_EXT_PRIO_ONE = 8'hf6;
	localparam logic [7:0] RST_BASIC_PRIO = 8'h80;
	localparam logic [7:0] RST_EXT_EN_ONE = 8'h00;
	localparam logic [7:0] RST_EXT_PRIO_ONE = 8'h00;
	localparam logic [7:0] BASIC_PRIO_WMASK = 8'h7f;
	localparam int BIT_UNUSED = 7;
	localparam int BIT_TIMER_THREE = 7;
	localparam int BIT_CMP_ONE = 6;
	localparam int BIT_CMP_ZERO = 5;
	localparam int BIT_COUNTER_ARRAY = 4;
	localparam int BIT_CONV_DONE = 3;
	localparam int BIT_WINDOW = 2;
	localparam int BIT_ALARM = 1;
	localparam int BIT_TWOWIRE = 0;
	localparam int NUM_SRC = 15;
	localparam int NUM_BASIC = 7;
	localparam logic [4:0] NO_VECTOR = 5'h1f;

	typedef enum logic [1:0]
	{
		IMPR_IDLE = 2'b00,
		IMPR_IN_LOW = 2'b01,
		IMPR_IN_HIGH = 2'b10,
		IMPR_IN_BOTH = 2'b11
	} impr_level_t;

	typedef struct packed
	{
		logic [7:0] basic_prio_reg;
		logic [7:0] ext_en_one_reg;
		logic [7:0] ext_prio_one_reg;
		impr_level_t level_reg;
		logic irq_valid_reg;
		logic [4:0] irq_vector_reg;
		logic irq_high_reg;
		logic [7:0] rdata_reg;
	} impr_state_t;
endpackage

// ### rtl/impr_sel_if.sv
// Pending request lines passed to the priority selector
`timescale 1ns/10ps
interface impr_sel_if;
	logic [impr_pkg::NUM_SRC-1:0] pend;
	logic [impr_pkg::NUM_SRC-1:0] high;
	logic found;
	logic [4:0] vector;
	logic is_high;
	modport ctrl (output pend, output high, input found, input vector,
		input is_high);
	modport sel (input pend, input high, output found, output vector,
		output is_high);
endinterface

// ### rtl/impr_select.sv
// Fixed-order priority selector over pending sources
`timescale 1ns/10ps
module impr_select
(
	impr_sel_if.sel s
);
	function automatic logic [4:0] lowest(
		input logic [impr_pkg::NUM_SRC-1:0] v);
		logic [4:0] r;
		r = impr_pkg::NO_VECTOR;
		for (int i = impr_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (v[i])
				r = 5'(i);
		end
		return r;
	endfunction

	logic [impr_pkg::NUM_SRC-1:0] hi_pend;
	logic [4:0] hi_vec;
	logic [4:0] lo_vec;

	always_comb
	begin
		hi_pend = s.pend & s.high;
		hi_vec = lowest(hi_pend);
		lo_vec = lowest(s.pend);
		// High level wins first, then lowest vector
		s.is_high = |hi_pend; // R14
		s.vector = s.is_high ? hi_vec : lo_vec; // R15
		s.found = |s.pend;
	end
endmodule

// ### rtl/impr_top.sv
// Interrupt enable, priority registers and request arbitration
// Operation
// R1 - Basic priority bit 7 reads one, ignores writes
// R2 - Basic priority at 0xB8, byte and bit access
// R3 - Basic priority bits 6..0 set source levels
// R4 - Enable bit 7 gates timer three overflows
// R5 - Enable bits 6,5 gate comparator edge flags
// R6 - Enable bit 4 gates counter array requests
// R7 - Enable bit 3 gates conversion complete
// R8 - Enable bit 2 gates window compare
// R9 - Enable bit 1 gates clock alarm
// R10 - Enable bit 0 gates two-wire bus
// R11 - Enable register at 0xE6, resets zero
// R12 - Extended priority at 0xF6, same order
// R13 - Global enable overrides all individual masks
// R14 - High preempts low, never another high
// R15 - Equal level served lowest vector first
`timescale 1ns/10ps
module impr_top
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic bit_wr,
	input wire logic [7:0] bit_addr,
	input wire logic bit_val,
	output logic [7:0] sfr_rdata,
	input wire logic global_irq_enable,
	input wire logic [6:0] basic_req,
	input wire logic timer_three_low_overflow,
	input wire logic timer_three_high_overflow,
	input wire logic cmp_one_rising_flag,
	input wire logic cmp_one_falling_flag,
	input wire logic cmp_zero_rising_flag,
	input wire logic cmp_zero_falling_flag,
	input wire logic counter_array_req,
	input wire logic conversion_done_flag,
	input wire logic window_hit_flag,
	input wire logic clock_alarm_req,
	input wire logic twowire_bus_req,
	input wire logic irq_ack,
	input wire logic irq_return,
	output logic irq_valid,
	output logic [4:0] irq_vector,
	output logic irq_high,
	output logic [7:0] en_ext_one,
	output logic [7:0] prio_basic
);
	impr_pkg::impr_state_t st_reg;
	impr_pkg::impr_state_t st_next;
	impr_sel_if sel_bus();
	logic [7:0] ext_src;
	logic [7:0] ext_gated;
	logic [impr_pkg::NUM_SRC-1:0] avail;
	logic allow_low;
	logic allow_high;
	logic bit_hit;
	logic ack_taken;

	impr_select u_sel
	(
		.s(sel_bus)
	);

	function automatic logic [7:0] bit_apply(input logic [7:0] v,
		input logic [2:0] pos, input logic b);
		logic [7:0] r;
		r = v;
		r[pos] = b;
		return r;
	endfunction

	// Vector order: basic 0..6, then extended bit b at vector 7+b
	function automatic logic [impr_pkg::NUM_SRC-1:0] vec_order(
		input logic [7:0] ext, input logic [6:0] basic);
		return {ext, basic}; // R15
	endfunction

	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input impr_pkg::impr_state_t s);
		logic [7:0] r;
		if (a == impr_pkg::ADDR_BASIC_PRIO)
			r = s.basic_prio_reg; // R1
		else if (a == impr_pkg::ADDR_EXT_EN_ONE)
			r = s.ext_en_one_reg;
		else if (a == impr_pkg::ADDR_EXT_PRIO_ONE)
			r = s.ext_prio_one_reg;
		else
			// Unmapped addresses read as zero
			r = 8'h00;
		return r;
	endfunction

	always_comb
	begin
		ext_src[impr_pkg::BIT_TIMER_THREE] = timer_three_low_overflow |
			timer_three_high_overflow; // R4
		ext_src[impr_pkg::BIT_CMP_ONE] = cmp_one_rising_flag |
			cmp_one_falling_flag; // R5
		ext_src[impr_pkg::BIT_CMP_ZERO] = cmp_zero_rising_flag |
			cmp_zero_falling_flag; // R5
		ext_src[impr_pkg::BIT_COUNTER_ARRAY] = counter_array_req; // R6
		ext_src[impr_pkg::BIT_CONV_DONE] = conversion_done_flag; // R7
		ext_src[impr_pkg::BIT_WINDOW] = window_hit_flag; // R8
		ext_src[impr_pkg::BIT_ALARM] = clock_alarm_req; // R9
		ext_src[impr_pkg::BIT_TWOWIRE] = twowire_bus_req; // R10
		// A zero enable bit blocks the source
		ext_gated = ext_src & st_reg.ext_en_one_reg; // R11
	end

	always_comb
	begin
		avail = global_irq_enable ?
			vec_order(ext_gated, basic_req) :
			'0; // R13
		sel_bus.high = vec_order(st_reg.ext_prio_one_reg,
			st_reg.basic_prio_reg[impr_pkg::NUM_BASIC-1:0]); // R3 R12
		// Nothing new while a high handler runs
		allow_high = !st_reg.level_reg[1]; // R14
		// A low handler lets only high sources through
		allow_low = st_reg.level_reg == impr_pkg::IMPR_IDLE; // R14
		sel_bus.pend = avail & (allow_low ? '1 :
			(allow_high ? sel_bus.high : '0));
	end

	always_comb
	begin
		st_next = st_reg;
		if (sfr_wr)
		begin
			if (sfr_addr == impr_pkg::ADDR_BASIC_PRIO)
				st_next.basic_prio_reg = (sfr_wdata &
					impr_pkg::BASIC_PRIO_WMASK) |
					impr_pkg::RST_BASIC_PRIO; // R1 R2
			else if (sfr_addr == impr_pkg::ADDR_EXT_EN_ONE)
				st_next.ext_en_one_reg = sfr_wdata; // R11
			else if (sfr_addr == impr_pkg::ADDR_EXT_PRIO_ONE)
				st_next.ext_prio_one_reg = sfr_wdata; // R12
		end
		// Bit address: upper five bits pick the register, low three the bit
		bit_hit = bit_wr &&
			bit_addr[7:3] == impr_pkg::ADDR_BASIC_PRIO[7:3] &&
			bit_addr[2:0] != 3'(impr_pkg::BIT_UNUSED); // R1
		// Bit write last, so it wins over a byte write in the same cycle
		if (bit_hit)
			st_next.basic_prio_reg = bit_apply(st_reg.basic_prio_reg,
				bit_addr[2:0], bit_val); // R2
		// Read data holds until the next read
		if (sfr_rd)
			st_next.rdata_reg = read_mux(sfr_addr, st_reg);
		ack_taken = irq_ack && st_reg.irq_valid_reg;
		// Request recomputed from the selector every cycle
		st_next.irq_valid_reg = sel_bus.found;
		st_next.irq_vector_reg = sel_bus.found ? sel_bus.vector :
			impr_pkg::NO_VECTOR; // R15
		st_next.irq_high_reg = sel_bus.found & sel_bus.is_high;
		case (st_reg.level_reg)
			impr_pkg::IMPR_IDLE:
			begin
				if (ack_taken)
					st_next.level_reg = st_reg.irq_high_reg ?
						impr_pkg::IMPR_IN_HIGH :
						impr_pkg::IMPR_IN_LOW; // R14
			end
			impr_pkg::IMPR_IN_LOW:
			begin
				if (irq_ack && st_reg.irq_valid_reg &&
					st_reg.irq_high_reg)
					st_next.level_reg = impr_pkg::IMPR_IN_BOTH; // R14
				else if (irq_return)
					st_next.level_reg = impr_pkg::IMPR_IDLE;
			end
			impr_pkg::IMPR_IN_HIGH:
			begin
				if (irq_return)
					st_next.level_reg = impr_pkg::IMPR_IDLE;
			end
			impr_pkg::IMPR_IN_BOTH:
			begin
				// Return from high resumes the low handler
				if (irq_return)
					st_next.level_reg = impr_pkg::IMPR_IN_LOW;
			end
			default:
				st_next.level_reg = impr_pkg::IMPR_IDLE;
		endcase
		// A taken request drops for one cycle so it is not taken twice
		if (ack_taken) // R14
		begin
			st_next.irq_valid_reg = 1'b0;
			st_next.irq_vector_reg = impr_pkg::NO_VECTOR;
			st_next.irq_high_reg = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_reg.basic_prio_reg <= impr_pkg::RST_BASIC_PRIO; // R1
			st_reg.ext_en_one_reg <= impr_pkg::RST_EXT_EN_ONE; // R11
			st_reg.ext_prio_one_reg <= impr_pkg::RST_EXT_PRIO_ONE;
			st_reg.level_reg <= impr_pkg::IMPR_IDLE;
			st_reg.irq_valid_reg <= 1'b0;
			st_reg.irq_vector_reg <= impr_pkg::NO_VECTOR;
			st_reg.irq_high_reg <= 1'b0;
			st_reg.rdata_reg <= 8'h00;
		end
		else
			st_reg <= st_next;
	end

	assign sfr_rdata = st_reg.rdata_reg;
	assign irq_valid = st_reg.irq_valid_reg;
	assign irq_vector = st_reg.irq_vector_reg;
	assign irq_high = st_reg.irq_high_reg;
	assign en_ext_one = st_reg.ext_en_one_reg;
	assign prio_basic = st_reg.basic_prio_reg;
endmodule

// ### tb/impr_assertions.sv
// Checker on the top ports of the mask and priority block
`timescale 1ns/10ps
module impr_assertions
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic bit_wr,
	input wire logic [7:0] bit_addr,
	input wire logic bit_val,
	input wire logic [7:0] sfr_rdata,
	input wire logic global_irq_enable,
	input wire logic [6:0] basic_req,
	input wire logic irq_ack,
	input wire logic irq_valid,
	input wire logic [7:0] en_ext_one,
	input wire logic [7:0] prio_basic
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic b8_wr;
	assign b8_wr = sfr_wr && sfr_addr == impr_pkg::ADDR_BASIC_PRIO;
	unused_one_a: assert property (prio_basic[7])
		else $error("basic priority bit 7 low");
	basic_write_a: assert property (b8_wr && !bit_wr |=>
		prio_basic == ($past(sfr_wdata) | 8'h80)) else $error("byte write");
	bit_write_a: assert property (bit_wr && !b8_wr &&
		bit_addr[7:3] == 5'h17 && bit_addr[2:0] != 3'h7 |=>
		prio_basic[$past(bit_addr[2:0])] == $past(bit_val))
		else $error("bit write");
	en_write_a: assert property (sfr_wr &&
		sfr_addr == impr_pkg::ADDR_EXT_EN_ONE |=>
		en_ext_one == $past(sfr_wdata)) else $error("enable write");
	en_reset_a: assert property ($rose(nrst) |-> en_ext_one == 8'h00)
		else $error("enable reset value");
	read_back_a: assert property (sfr_rd && !sfr_wr &&
		sfr_addr == impr_pkg::ADDR_EXT_EN_ONE |=>
		sfr_rdata == $past(en_ext_one)) else $error("enable read");
	global_gate_a: assert property (!global_irq_enable [*2]
		|-> !irq_valid) else $error("request with global off");
	mask_gate_a: assert property (en_ext_one == 8'h00 &&
		basic_req == 7'h00 |=> !irq_valid) else $error("masked request");
	ack_drop_a: assert property (irq_ack && irq_valid |=>
		!irq_valid) else $error("request held over ack");
	cover property (irq_ack && irq_valid);
	cover property (bit_wr);
	cover property (b8_wr);
endmodule
bind impr_top impr_assertions chk_u (.*);

// ### tb/impr_core_model.sv
// Core side: takes requests and returns from handlers on command
`timescale 1ns/10ps
module impr_core_model
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic irq_valid,
	input wire logic [4:0] irq_vector,
	input wire logic run,
	input wire logic [1:0] dly,
	input wire logic leave,
	output logic irq_ack,
	output logic irq_return,
	output logic [4:0] last_vec,
	output logic [1:0] depth
);
	logic [1:0] cnt;
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			{irq_ack, irq_return, last_vec, depth, cnt} <= '0;
		else
		begin
			irq_ack <= 1'b0;
			irq_return <= 1'b0;
			// Return only from a taken handler
			if (leave && depth != 2'h0)
			begin
				irq_return <= 1'b1;
				depth <= depth - 2'h1;
			end
			else if (irq_ack || !run || !irq_valid)
				cnt <= 2'h0;
			else if (cnt != dly)
				cnt <= cnt + 2'h1;
			else
			begin
				irq_ack <= 1'b1;
				last_vec <= irq_vector;
				depth <= depth + 2'h1;
			end
		end
endmodule

// ### tb/impr_top_bench.sv
// Register and request bench for the mask and priority block
`timescale 1ns/10ps
module impr_top_bench;
	localparam logic [7:0] PB = impr_pkg::ADDR_BASIC_PRIO;
	localparam logic [7:0] EN = impr_pkg::ADDR_EXT_EN_ONE;
	localparam logic [7:0] PX = impr_pkg::ADDR_EXT_PRIO_ONE;
	logic sys_clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic bit_wr = 1'b0, bit_val = 1'b0, global_irq_enable = 1'b0;
	logic run = 1'b1, leave = 1'b0, irq_ack, irq_return, irq_valid, irq_high;
	logic [7:0] sfr_addr = '0, sfr_wdata = '0, bit_addr = '0;
	logic [7:0] sfr_rdata, en_ext_one, prio_basic;
	logic [6:0] basic_req = '0;
	logic [10:0] src = '0;
	logic [4:0] irq_vector, last_vec;
	logic [1:0] depth, dly = '0;
	int n_fail = 0, comparisons = 0, b;
	always #20 sys_clk = ~sys_clk;
	impr_top dut_u (.*, .twowire_bus_req(src[0]), .clock_alarm_req(src[1]),
		.window_hit_flag(src[2]), .conversion_done_flag(src[3]),
		.counter_array_req(src[4]), .cmp_zero_falling_flag(src[5]),
		.cmp_zero_rising_flag(src[6]), .cmp_one_falling_flag(src[7]),
		.cmp_one_rising_flag(src[8]), .timer_three_low_overflow(src[9]),
		.timer_three_high_overflow(src[10]));
	impr_core_model core_u (.*);
	task chk(input string nm, input logic [7:0] s, x);
		if (s !== x)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, x, s);
		end
		comparisons++;
	endtask
	task nap(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// Bit writes use the same address byte: 0xb8 plus the bit index
	task put(input logic byt, input logic [7:0] a, d);
		@(negedge sys_clk);
		{sfr_addr, sfr_wdata, bit_addr, bit_val} = {a, d, a, d[0]};
		{sfr_wr, bit_wr} = {byt, !byt};
		nap(1);
		{sfr_wr, bit_wr} = 2'b00;
	endtask
	task rd(input logic [7:0] a, x);
		@(negedge sys_clk);
		{sfr_addr, sfr_rd} = {a, 1'b1};
		nap(1);
		sfr_rd = 1'b0;
		chk("rdata", sfr_rdata, x);
	endtask
	task till(input logic [1:0] d);
		for (int k = 0; k < 12 && depth !== d; k++) nap(1);
		chk("depth", 8'(depth), 8'(d));
	endtask
	task lv;
		nap(1);
		leave = 1'b1;
		nap(1);
		leave = 1'b0;
	endtask
	task tally_and_finish;
		if (n_fail == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		nap(6);
		nrst = 1'b1;
		rd(PB, 8'h80);
		rd(PX, 8'h00);
		put(1'b1, PB, 8'h7f);
		rd(PB, 8'hff);
		put(1'b1, PB, 8'h00);
		put(1'b0, 8'hbf, 8'h00);
		put(1'b0, 8'hb9, 8'h01);
		rd(PB, 8'h82);
		chk("prio", prio_basic, 8'h82);
		put(1'b1, 8'h01, 8'hff);
		rd(8'h01, 8'h00);
		rd(EN, 8'h00);
		put(1'b1, PX, 8'h5a);
		rd(PX, 8'h5a);
		put(1'b1, PX, 8'h00);
		put(1'b1, EN, 8'hff);
		chk("en", en_ext_one, 8'hff);
		src = 11'h001;
		nap(4);
		chk("valid", 8'(irq_valid), 8'h00);
		global_irq_enable = 1'b1;
		till(2'h1);
		chk("vec", 8'(last_vec), 8'h07);
		src = '0;
		lv;
		// Each flag alone, first with its own enable bit cleared
		for (int i = 0; i < 11; i++)
		begin
			b = i < 5 ? i : 5 + (i - 5) / 2;
			put(1'b1, EN, ~(8'h01 << b));
			src = 11'h001 << i;
			nap(3);
			chk("mask", 8'(irq_valid), 8'h00);
			put(1'b1, EN, 8'h01 << b);
			till(2'h1);
			chk("vec", 8'(last_vec), 8'(7 + b));
			src = '0;
			lv;
		end
		{run, src} = {1'b0, 11'h201};
		put(1'b1, EN, 8'hff);
		nap(2);
		chk("vector", {irq_high, 2'h0, irq_vector}, 8'h07);
		put(1'b1, PX, 8'h80);
		nap(2);
		chk("vector", {irq_high, 2'h0, irq_vector}, 8'h8e);
		basic_req = 7'h41;
		put(1'b1, PB, 8'h40);
		nap(2);
		chk("vector", {irq_high, 2'h0, irq_vector}, 8'h86);
		{basic_req, run, dly, src} = {7'h00, 1'b1, 2'h3, 11'h001};
		till(2'h1);
		src = 11'h003;
		nap(4);
		chk("valid", 8'(irq_valid), 8'h00);
		src = 11'h20b;
		till(2'h2);
		chk("vec", 8'(last_vec), 8'h0e);
		put(1'b1, PX, 8'h88);
		nap(4);
		chk("valid", 8'(irq_valid), 8'h00);
		src = '0;
		lv;
		lv;
		tally_and_finish;
	end
	initial
	begin
		#200000;
		n_fail++;
		tally_and_finish;
	end
endmodule
